// ==== rtl/sspsw_cfg.svh ====
// constants of the switchable-pin synchronous serial channel
`ifndef SSPSW_CFG_SVH
`define SSPSW_CFG_SVH
// ==================================================
// serial mode register layout
`define SSPSW_MODE_RESET 8'h00
`define SSPSW_MODE_TX_EN 7
`define SSPSW_MODE_RX_EN 6
`define SSPSW_MODE_PIN_SET 4
`define SSPSW_MODE_FIRST_BIT 3
`define SSPSW_MODE_CLS_HI 1
`define SSPSW_MODE_CLS_LO 0
// ==================================================
// baud timer control layout
`define SSPSW_TMC_RESET 8'h00
`define SSPSW_TMC_RUN 7
`define SSPSW_TMC_N_HI 1
`define SSPSW_TMC_N_LO 0
// prescaler masks for n = 0, 2, 4, 5
`define SSPSW_MASK_N0 5'h00
`define SSPSW_MASK_N2 5'h03
`define SSPSW_MASK_N4 5'h0f
`define SSPSW_MASK_N5 5'h1f
// ==================================================
// fixed serial clock half periods (fclk/8, fclk/32)
`define SSPSW_MASK_DIV8 5'h03
`define SSPSW_MASK_DIV32 5'h0f
`define SSPSW_LAST_BIT 3'h7
`endif

// ==== rtl/sspsw_pkg.sv ====
// types of the switchable-pin synchronous serial channel
package sspsw_pkg;
  typedef enum logic [1:0] {
    SSPSW_CLS_EXT = 2'b00,
    SSPSW_CLS_BRG = 2'b01,
    SSPSW_CLS_DIV32 = 2'b10,
    SSPSW_CLS_DIV8 = 2'b11
  } sspsw_clk_sel_t;
  typedef enum logic [1:0] {
    SSPSW_ST_IDLE = 2'b01,
    SSPSW_ST_RUN = 2'b10
  } sspsw_state_t;
endpackage

// ==== rtl/sspsw_baud_gen.sv ====
// shared baud rate generator: prescaler, 10-bit timer, compare
`include "sspsw_cfg.svh"
module sspsw_baud_gen #(
  parameter int CNT_W = 10
) (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic ctrl_wr_in,
  input wire logic [7:0] ctrl_data_in,
  input wire logic cmp_wr_in,
  input wire logic [CNT_W-1:0] cmp_data_in,
  output logic [7:0] ctrl_out,
  output logic [CNT_W-1:0] cmp_out,
  output logic [CNT_W-1:0] count_out,
  output logic baud_level_out
);
  logic [7:0] ctrl_q;
  logic [CNT_W-1:0] cmp_q;
  logic [CNT_W-1:0] count_q;
  logic [4:0] pre_q;
  logic level_q;
  logic [4:0] n_mask;
  logic run;
  logic count_en;
  logic match;
  // ==================================================
  // count clock: fclk / 2^n
  assign run = ctrl_q[`SSPSW_TMC_RUN];
  assign n_mask = (ctrl_q[`SSPSW_TMC_N_HI:`SSPSW_TMC_N_LO] == 2'h0) ? `SSPSW_MASK_N0 :
                  (ctrl_q[`SSPSW_TMC_N_HI:`SSPSW_TMC_N_LO] == 2'h1) ? `SSPSW_MASK_N2 :
                  (ctrl_q[`SSPSW_TMC_N_HI:`SSPSW_TMC_N_LO] == 2'h2) ? `SSPSW_MASK_N4 : `SSPSW_MASK_N5;
  assign count_en = run && ((pre_q & n_mask) == n_mask);
  assign match = (count_q == cmp_q);
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctrl_q <= `SSPSW_TMC_RESET;
      pre_q <= 5'h00;
      count_q <= '0;
      level_q <= 1'b0;
    end else begin
      if (ctrl_wr_in) begin
        ctrl_q <= ctrl_data_in;
      end
      pre_q <= run ? pre_q + 5'h01 : 5'h00;
      if (!run) begin
        count_q <= '0;
      end else if (count_en) begin
        count_q <= match ? '0 : count_q + 1'b1;
        level_q <= level_q ^ match;
      end
    end
  end
  // compare holds no reset value: software loads it before starting
  always_ff @(posedge sys_clk_in) begin
    if (cmp_wr_in) begin
      cmp_q <= cmp_data_in;
    end
  end
  // timer is read only: no write path exists
  assign count_out = count_q;
  assign ctrl_out = ctrl_q;
  assign cmp_out = cmp_q;
  assign baud_level_out = level_q;
  // ==================================================
  // checks
  AST_BRG_WRAP: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    (count_en && match) |=> (count_q == '0))
    else $error("baud timer did not clear after match");
  AST_BRG_TOGGLE: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    (run && !(count_en && match)) |=> $stable(level_q))
    else $error("baud output moved without a match");
endmodule // sspsw_baud_gen

// ==== rtl/sspsw_top.sv ====
// three-wire synchronous serial channel with two switchable pin sets
`include "sspsw_cfg.svh"
module sspsw_top (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic mode_wr_in,
  input wire logic [7:0] mode_data_in,
  output logic [7:0] serial_mode_register_out,
  input wire logic shift_wr_in,
  input wire logic shift_rd_in,
  input wire logic [7:0] shift_data_in,
  output logic [7:0] shift_register_out,
  input wire logic baud_timer_control_wr_in,
  input wire logic [7:0] baud_timer_control_data_in,
  output logic [7:0] baud_timer_control_out,
  input wire logic baud_compare_wr_in,
  input wire logic [9:0] baud_compare_data_in,
  output logic [9:0] baud_compare_out,
  output logic [9:0] baud_timer_out,
  output logic baud_level_out,
  output logic transfer_done_irq_out,
  output logic busy_out,
  input wire logic clock_pin_set_a_in,
  output logic clock_pin_set_a_out,
  output logic clock_pin_set_a_oe_n_out,
  output logic data_out_pin_set_a_out,
  output logic data_out_pin_set_a_oe_n_out,
  input wire logic data_in_pin_set_a_in,
  input wire logic clock_pin_set_b_in,
  output logic clock_pin_set_b_out,
  output logic clock_pin_set_b_oe_n_out,
  output logic data_out_pin_set_b_out,
  output logic data_out_pin_set_b_oe_n_out,
  input wire logic data_in_pin_set_b_in
);
  import sspsw_pkg::*;
  logic [7:0] mode_q;
  logic [7:0] sr_q;
  logic [2:0] bitcnt_q;
  sspsw_state_t state_q;
  logic sclk_q;
  logic so_q;
  logic done_q;
  logic [4:0] pre_q;
  logic baud_prev_q;
  logic [3:0] meta_q;
  logic [3:0] sync_q;
  logic ext_prev_q;
  logic [1:0] ck_oe_n_q;
  logic [1:0] so_oe_n_q;
  logic baud_level;
  logic [9:0] baud_count;
  logic [7:0] tmc;
  logic [9:0] cmp;
  // ==================================================
  // baud rate generator, its output also leaves the block
  sspsw_baud_gen #(
    .CNT_W(10)
  ) u_baud (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .ctrl_wr_in(baud_timer_control_wr_in),
    .ctrl_data_in(baud_timer_control_data_in),
    .cmp_wr_in(baud_compare_wr_in),
    .cmp_data_in(baud_compare_data_in),
    .ctrl_out(tmc),
    .cmp_out(cmp),
    .count_out(baud_count),
    .baud_level_out(baud_level)
  );
  // ==================================================
  // decode
  logic tx_en;
  logic rx_en;
  logic set_b;
  logic lsb_first;
  sspsw_clk_sel_t clk_sel;
  logic internal_clk;
  logic int_tick;
  logic sel_ck;
  logic sel_di;
  logic ext_rise;
  logic ext_fall;
  logic rise_ev;
  logic fall_ev;
  logic rx_arm;
  logic start;
  logic last_bit;
  logic abort;
  assign tx_en = mode_q[`SSPSW_MODE_TX_EN];
  assign rx_en = mode_q[`SSPSW_MODE_RX_EN];
  assign set_b = mode_q[`SSPSW_MODE_PIN_SET];
  assign lsb_first = mode_q[`SSPSW_MODE_FIRST_BIT];
  assign clk_sel = sspsw_clk_sel_t'(mode_q[`SSPSW_MODE_CLS_HI:`SSPSW_MODE_CLS_LO]);
  assign internal_clk = (clk_sel != SSPSW_CLS_EXT);
  // sys_clk_in is fclk, already the oscillator halved outside
  // the select is combinational: a change mid-character gives a bad period
  assign int_tick = (clk_sel == SSPSW_CLS_BRG) ? (baud_level != baud_prev_q) :
                    (clk_sel == SSPSW_CLS_DIV8) ? ((pre_q & `SSPSW_MASK_DIV8) == `SSPSW_MASK_DIV8) :
                    ((pre_q & `SSPSW_MASK_DIV32) == `SSPSW_MASK_DIV32);
  assign sel_ck = set_b ? sync_q[1] : sync_q[0];
  assign sel_di = set_b ? sync_q[3] : sync_q[2];
  assign ext_rise = sel_ck && !ext_prev_q;
  assign ext_fall = !sel_ck && ext_prev_q;
  assign rise_ev = (state_q == SSPSW_ST_RUN) && (internal_clk ? (int_tick && !sclk_q) : ext_rise);
  assign fall_ev = (state_q == SSPSW_ST_RUN) && (internal_clk ? (int_tick && sclk_q) : ext_fall);
  assign rx_arm = mode_wr_in && mode_data_in[`SSPSW_MODE_RX_EN] && !rx_en && !mode_data_in[`SSPSW_MODE_TX_EN];
  assign start = (state_q == SSPSW_ST_IDLE) && ((shift_wr_in && tx_en) || rx_arm
                 || (shift_rd_in && rx_en && !tx_en));
  assign last_bit = (bitcnt_q == `SSPSW_LAST_BIT);
  // clearing both enables drops a character that lost step with the clock
  assign abort = mode_wr_in && !mode_data_in[`SSPSW_MODE_TX_EN] && !mode_data_in[`SSPSW_MODE_RX_EN];
  // ==================================================
  // pin input synchronisers, edge history and free-running prescaler
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta_q <= 4'hf;
      sync_q <= 4'hf;
      ext_prev_q <= 1'b1;
      pre_q <= 5'h00;
      baud_prev_q <= 1'b0;
    end else begin
      meta_q <= {data_in_pin_set_b_in, data_in_pin_set_a_in, clock_pin_set_b_in, clock_pin_set_a_in};
      sync_q <= meta_q;
      ext_prev_q <= sel_ck;
      pre_q <= pre_q + 5'h01;
      baud_prev_q <= baud_level;
    end
  end
  // ==================================================
  // mode register and transfer engine
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mode_q <= `SSPSW_MODE_RESET;
      sr_q <= 8'h00;
      bitcnt_q <= 3'h0;
      state_q <= SSPSW_ST_IDLE;
      sclk_q <= 1'b1;
      so_q <= 1'b1;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (mode_wr_in) begin
        mode_q <= mode_data_in;
      end
      if (shift_wr_in && state_q == SSPSW_ST_IDLE) begin
        sr_q <= shift_data_in;
      end
      case (state_q)
        SSPSW_ST_IDLE: begin
          sclk_q <= 1'b1;
          bitcnt_q <= 3'h0;
          if (start && !abort) begin
            state_q <= SSPSW_ST_RUN;
          end
        end
        SSPSW_ST_RUN: begin
          if (abort) begin
            state_q <= SSPSW_ST_IDLE;
          end else if (fall_ev) begin
            if (internal_clk) begin
              sclk_q <= 1'b0;
            end
            so_q <= lsb_first ? sr_q[0] : sr_q[7];
          end else if (rise_ev) begin
            if (internal_clk) begin
              sclk_q <= 1'b1;
            end
            // without receive enabled zeros are shifted in
            sr_q <= lsb_first ? {sel_di && rx_en, sr_q[7:1]} : {sr_q[6:0], sel_di && rx_en};
            bitcnt_q <= bitcnt_q + 3'h1;
            if (last_bit) begin
              done_q <= 1'b1;
              state_q <= SSPSW_ST_IDLE;
            end
          end
        end
        default: begin
          state_q <= SSPSW_ST_IDLE;
        end
      endcase
    end
  end
  // ==================================================
  // pin drivers, enables low while driving
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ck_oe_n_q <= 2'b11;
      so_oe_n_q <= 2'b11;
    end else begin
      ck_oe_n_q <= {!(set_b && internal_clk), !(!set_b && internal_clk)};
      so_oe_n_q <= {!(set_b && tx_en), !(!set_b && tx_en)};
    end
  end
  assign serial_mode_register_out = mode_q;
  assign shift_register_out = sr_q;
  assign baud_timer_control_out = tmc;
  assign baud_compare_out = cmp;
  assign baud_timer_out = baud_count;
  assign baud_level_out = baud_level;
  assign transfer_done_irq_out = done_q;
  assign busy_out = state_q[1];
  assign clock_pin_set_a_out = sclk_q;
  assign clock_pin_set_b_out = sclk_q;
  assign clock_pin_set_a_oe_n_out = ck_oe_n_q[0];
  assign clock_pin_set_b_oe_n_out = ck_oe_n_q[1];
  assign data_out_pin_set_a_out = so_q;
  assign data_out_pin_set_b_out = so_q;
  assign data_out_pin_set_a_oe_n_out = so_oe_n_q[0];
  assign data_out_pin_set_b_oe_n_out = so_oe_n_q[1];
  // ==================================================
  // checks
  AST_PIN_SET_A: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    (!set_b && tx_en) |=> !data_out_pin_set_a_oe_n_out)
    else $error("set a data pin not driven");
  AST_PIN_SET_B: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    (set_b && internal_clk) |=> !clock_pin_set_b_oe_n_out)
    else $error("set b clock pin not driven");
  AST_UNSEL_HIZ: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    set_b |=> (clock_pin_set_a_oe_n_out && data_out_pin_set_a_oe_n_out))
    else $error("unselected set driven");
  AST_EXT_INPUT: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    (clk_sel == SSPSW_CLS_EXT) |=> (clock_pin_set_a_oe_n_out && clock_pin_set_b_oe_n_out))
    else $error("clock pin driven with external clock");
  AST_DIV8_PERIOD: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    (clk_sel == SSPSW_CLS_DIV8 && int_tick && $stable(mode_q))
      |=> (!int_tick || clk_sel != SSPSW_CLS_DIV8) [*3] ##1 (int_tick || clk_sel != SSPSW_CLS_DIV8))
    else $error("fclk/8 half period wrong");
  AST_RX_SAMPLE: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    (rise_ev && !lsb_first && rx_en && !abort) |=> (sr_q[0] == $past(sel_di)))
    else $error("received bit not captured");
  AST_DONE_8: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    done_q |-> ($past(bitcnt_q) == `SSPSW_LAST_BIT && $past(rise_ev) && state_q == SSPSW_ST_IDLE))
    else $error("done without eighth edge");
  AST_IDLE_HIGH: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    (state_q == SSPSW_ST_IDLE) |=> (clock_pin_set_a_out && clock_pin_set_b_out))
    else $error("clock not high between characters");
  AST_TX_OFF_HIZ: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    !tx_en |=> (data_out_pin_set_a_oe_n_out && data_out_pin_set_b_oe_n_out))
    else $error("data out driven with transmit off");
  AST_STARTS: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    (start && !abort) |=> (busy_out && bitcnt_q == 3'h0))
    else $error("transfer did not start");
endmodule // sspsw_top

// ==== tb/sspsw_peer.sv ====
// far-side peripheral model for the three-wire serial channel
module sspsw_peer (
  input wire logic sclk_in,
  input wire logic mosi_in,
  input wire logic lsb_first_in,
  input wire logic load_in,
  input wire logic [7:0] tx_byte_in,
  input wire logic ext_go_in,
  output logic miso_out,
  output logic ext_clk_out,
  output logic [7:0] rx_byte_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh_q;
  logic rose_q;
  initial begin
    ext_clk_out = 1'b1;
    rx_byte_out = 8'h00;
    sh_q = 8'h00;
    rose_q = 1'b0;
  end
  assign miso_out = lsb_first_in ? sh_q[0] : sh_q[7];
  always @(posedge load_in) begin
    sh_q = tx_byte_in;
    rose_q = 1'b0;
  end
  // ==================================================
  // shifting
  // capture on rise, move on fall only after a rise, so the first bit survives the first fall
  always @(posedge sclk_in) begin
    rx_byte_out <= lsb_first_in ? {mosi_in, rx_byte_out[7:1]} : {rx_byte_out[6:0], mosi_in};
    rose_q <= 1'b1;
  end
  always @(negedge sclk_in) begin
    if (rose_q) begin
      sh_q <= lsb_first_in ? {~sh_q[0], sh_q[7:1]} : {sh_q[6:0], ~sh_q[7]};
    end
  end
  // ==================================================
  // external clock: eight periods, idle high, stands still between frames
  always @(posedge ext_go_in) begin
    repeat (8) begin
      #100 ext_clk_out = 1'b0;
      #100 ext_clk_out = 1'b1;
    end
  end
endmodule // sspsw_peer

// ==== tb/sync_serial_pin_switch_brg_bench.sv ====
// self-checking bench of the switchable-pin serial channel
module sync_serial_pin_switch_brg_bench;
  import sspsw_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_in, reset_n_in, mode_wr_in, shift_wr_in, shift_rd_in;
  logic baud_timer_control_wr_in, baud_compare_wr_in;
  logic [7:0] mode_data_in, shift_data_in, baud_timer_control_data_in;
  logic [9:0] baud_compare_data_in;
  logic [7:0] serial_mode_register_out, shift_register_out, baud_timer_control_out;
  logic [9:0] baud_compare_out, baud_timer_out;
  logic baud_level_out, transfer_done_irq_out, busy_out;
  logic clock_pin_set_a_out, clock_pin_set_a_oe_n_out, data_out_pin_set_a_out, data_out_pin_set_a_oe_n_out;
  logic clock_pin_set_b_out, clock_pin_set_b_oe_n_out, data_out_pin_set_b_out, data_out_pin_set_b_oe_n_out;
  logic use_b, lsb, p_load, p_go, ext_clk, miso;
  logic [7:0] p_byte, p_rx;
  int num_errors = 0;
  int checks_done = 0;
  // released clock pins idle high; released data pins show the inverse of the last value
  wire logic clk_a = clock_pin_set_a_oe_n_out ? (use_b | ext_clk) : clock_pin_set_a_out;
  wire logic clk_b = clock_pin_set_b_oe_n_out ? (~use_b | ext_clk) : clock_pin_set_b_out;
  wire logic do_a = data_out_pin_set_a_out ^ data_out_pin_set_a_oe_n_out;
  wire logic do_b = data_out_pin_set_b_out ^ data_out_pin_set_b_oe_n_out;
  sspsw_top sspsw_top_i (.sys_clk_in, .reset_n_in, .mode_wr_in, .mode_data_in, .serial_mode_register_out,
    .shift_wr_in, .shift_rd_in, .shift_data_in, .shift_register_out, .baud_timer_control_wr_in,
    .baud_timer_control_data_in, .baud_timer_control_out, .baud_compare_wr_in, .baud_compare_data_in,
    .baud_compare_out, .baud_timer_out, .baud_level_out, .transfer_done_irq_out, .busy_out,
    .clock_pin_set_a_in(clk_a), .clock_pin_set_a_out, .clock_pin_set_a_oe_n_out, .data_out_pin_set_a_out,
    .data_out_pin_set_a_oe_n_out, .data_in_pin_set_a_in(miso ^ use_b), .clock_pin_set_b_in(clk_b),
    .clock_pin_set_b_out, .clock_pin_set_b_oe_n_out, .data_out_pin_set_b_out, .data_out_pin_set_b_oe_n_out,
    .data_in_pin_set_b_in(miso ^ ~use_b));
  sspsw_peer sspsw_peer_i (.sclk_in(use_b ? clk_b : clk_a), .mosi_in(use_b ? do_b : do_a), .lsb_first_in(lsb),
    .load_in(p_load), .tx_byte_in(p_byte), .ext_go_in(p_go), .miso_out(miso), .ext_clk_out(ext_clk),
    .rx_byte_out(p_rx));
  always #10 sys_clk_in = ~sys_clk_in;
  // ==================================================
  // shared tasks
  task automatic check(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask
  task automatic results;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wr(input int which, input logic [9:0] d);
    {mode_data_in, shift_data_in, baud_timer_control_data_in, baud_compare_data_in} = {d[7:0], d[7:0], d[7:0], d};
    {baud_compare_wr_in, baud_timer_control_wr_in, shift_wr_in, mode_wr_in} = 4'h1 << which;
    @(negedge sys_clk_in);
    {baud_compare_wr_in, baud_timer_control_wr_in, shift_wr_in, mode_wr_in} = 4'h0;
    @(negedge sys_clk_in);
  endtask
  task automatic gap(output int n);
    logic lv;
    lv = baud_level_out;
    n = 0;
    while (baud_level_out === lv && n < 400) begin
      @(negedge sys_clk_in);
      n++;
    end
  endtask
  // one character both ways; a second write mid-character must be ignored
  task automatic xfer(input logic [7:0] mode, input logic [7:0] txd, input logic [7:0] pd, input logic ext);
    int dones;
    int n;
    logic bad;
    {dones, n, bad, use_b, lsb, p_byte, p_load} = {32'h0, 32'h0, 1'b0, mode[4], mode[3], pd, 1'b1};
    @(negedge sys_clk_in);
    p_load = 1'b0;
    wr(0, {2'h0, mode});
    check(serial_mode_register_out === mode, "mode readback");
    wr(1, {2'h0, txd});
    check(busy_out === 1'b1, "busy after start");
    wr(1, {2'h0, ~txd});
    p_go = ext;
    while (busy_out !== 1'b0 && n < 2000) begin
      @(negedge sys_clk_in);
      p_go = 1'b0;
      n++;
      dones += (transfer_done_irq_out === 1'b1);
      bad |= (use_b ? {clock_pin_set_a_oe_n_out, data_out_pin_set_a_oe_n_out, clock_pin_set_b_oe_n_out,
        data_out_pin_set_b_oe_n_out} : {clock_pin_set_b_oe_n_out, data_out_pin_set_b_oe_n_out,
        clock_pin_set_a_oe_n_out, data_out_pin_set_a_oe_n_out}) !== {2'b11, ext, 1'b0};
    end
    repeat (3) begin
      @(negedge sys_clk_in);
      dones += (transfer_done_irq_out === 1'b1);
    end
    check(n < 2000, "transfer hung");
    check(!bad, "pin enables wrong");
    check(dones == 1, "done pulse count");
    check(p_rx === txd, "peer received byte");
    check(shift_register_out === pd, "device received byte");
    check((use_b ? clk_b : clk_a) === 1'b1, "clock idle level");
  endtask
  // ==================================================
  // scenarios
  task automatic t_reset;
    check(serial_mode_register_out === 8'h00, "mode reset");
    check(baud_timer_control_out === 8'h00, "timer control reset");
    check(baud_timer_out === 10'h000, "timer reset");
    check({clock_pin_set_a_oe_n_out, data_out_pin_set_a_oe_n_out, clock_pin_set_b_oe_n_out,
      data_out_pin_set_b_oe_n_out} === 4'hf, "enables at reset");
    check({clock_pin_set_a_out, clock_pin_set_b_out, busy_out} === 3'b110, "idle levels");
    $display("test reset done");
  endtask
  task automatic t_set_a;
    xfer({6'h30, SSPSW_CLS_DIV8}, 8'ha5, 8'h3c, 1'b0);
    $display("test set a done");
  endtask
  task automatic t_set_b;
    xfer({6'h36, SSPSW_CLS_DIV32}, 8'h81, 8'h4e, 1'b0);
    $display("test set b done");
  endtask
  task automatic t_baud;
    int n;
    int want [4] = '{5, 20, 80, 160};
    wr(3, 10'h004);
    check(baud_compare_out === 10'h004, "compare readback");
    for (int k = 0; k < 4; k++) begin
      wr(2, {8'h20, k[1:0]});
      check(baud_timer_control_out === {6'h20, k[1:0]}, "timer control readback");
      gap(n);
      gap(n);
      gap(n);
      check(n == want[k], "generator half period");
      check(baud_timer_out <= 10'h004, "timer bound");
    end
    wr(2, 10'h081);
    xfer({6'h30, SSPSW_CLS_BRG}, 8'h5a, 8'hc3, 1'b0);
    wr(2, 10'h000);
    gap(n);
    gap(n);
    check(n == 400, "generator stopped");
    $display("test baud done");
  endtask
  task automatic t_ext;
    xfer({6'h30, SSPSW_CLS_EXT}, 8'h6b, 8'hd2, 1'b1);
    p_go = 1'b1;
    @(negedge sys_clk_in);
    p_go = 1'b0;
    repeat (100) @(negedge sys_clk_in);
    check(busy_out === 1'b0 && shift_register_out === 8'hd2, "idle clock moved the shift register");
    wr(0, 10'h000);
    check({data_out_pin_set_a_oe_n_out, data_out_pin_set_b_oe_n_out} === 2'b11, "tx off released");
    $display("test external done");
  endtask
  // receive only: started once by raising receive enable, once by a read
  task automatic rx_one(input logic [7:0] pd, input logic by_read);
    int n;
    {p_byte, p_load, n} = {pd, 1'b1, 32'h0};
    @(negedge sys_clk_in);
    p_load = 1'b0;
    if (by_read) begin
      shift_rd_in = 1'b1;
      @(negedge sys_clk_in);
      shift_rd_in = 1'b0;
      @(negedge sys_clk_in);
    end else begin
      wr(0, 10'h043);
    end
    check(busy_out === 1'b1, "receive started");
    while (busy_out !== 1'b0 && n < 2000) begin
      @(negedge sys_clk_in);
      n++;
      check({data_out_pin_set_a_oe_n_out, data_out_pin_set_b_oe_n_out} === 2'b11, "data out driven in receive");
    end
    repeat (3) @(negedge sys_clk_in);
    check(n < 2000 && shift_register_out === pd, "received byte");
  endtask
  task automatic t_rx;
    rx_one(8'h96, 1'b0);
    rx_one(8'h2d, 1'b1);
    wr(1, 10'h055);
    check(busy_out === 1'b0, "write with transmit off started");
    $display("test receive done");
  endtask
  // ==================================================
  // main sequence and watchdog
  initial begin
    {sys_clk_in, reset_n_in, mode_wr_in, shift_wr_in, shift_rd_in, baud_timer_control_wr_in} = 6'h0;
    {baud_compare_wr_in, use_b, lsb, p_load, p_go} = 5'h0;
    {mode_data_in, shift_data_in, baud_timer_control_data_in, baud_compare_data_in, p_byte} = 42'h0;
    repeat (16) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    reset_n_in = 1'b1;
    t_reset;
    t_set_a;
    t_set_b;
    t_baud;
    t_ext;
    t_rx;
    results;
  end
  initial begin
    repeat (30000) @(posedge sys_clk_in);
    num_errors++;
    $display("MISMATCH %0t watchdog expired", $time);
    results;
  end
endmodule // sync_serial_pin_switch_brg_bench
